/* File: core/edge_irq.sv */
module edge_irq (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // synchronised levels and per-pin arming
  input  wire logic [15:0] level_i,
  input  wire logic [15:0] rise_arm_i,
  input  wire logic [15:0] fall_arm_i,
  // report handshake
  input  wire logic [15:0] ack_i,
  output logic      [15:0] pending_o,
  output logic             irq_o
);

  logic [15:0] prev_r;
  logic [15:0] prev_nxt;
  logic        primed_r;
  logic        primed_nxt;
  logic [15:0] pend_r;
  logic [15:0] pend_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [15:0] hit;

  // ----------------------------------------------------------------
  // transition detect and pending latch
  // ----------------------------------------------------------------
  always_comb begin
    prev_nxt   = level_i;
    primed_nxt = 1'b1;
    // no event until a first sample has been taken
    hit        = primed_r ? ((level_i & ~prev_r & rise_arm_i) |
                             (~level_i & prev_r & fall_arm_i)) : 16'h0000;
    // new event wins over a simultaneous acknowledge
    pend_nxt   = hit | (pend_r & ~ack_i);
    irq_nxt    = |pend_nxt;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_r   <= 16'h0000;
      primed_r <= 1'b0;
      pend_r   <= 16'h0000;
      irq_r    <= 1'b0;
    end else begin
      prev_r   <= prev_nxt;
      primed_r <= primed_nxt;
      pend_r   <= pend_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign pending_o = pend_r;
  assign irq_o     = irq_r;

endmodule // edge_irq

/* File: core/gpio_bank_low_pins.sv */
`include "gpio_bank_regs.svh"

module gpio_bank_low_pins (
  // clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     reset_n_i,
  // register access
  input  wire gpio_bank_pkg::reg_req_t  req_i,
  output gpio_bank_pkg::reg_rsp_t       rsp_o,
  // pins
  input  wire logic [15:0]              pin_in_i,
  output gpio_bank_pkg::pad_ctrl_t      pad_o,
  // interrupt report
  input  wire logic [15:0]              irq_ack_i,
  output logic      [15:0]              irq_pending_o,
  output logic                          irq_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input gpio_bank_pkg::reg_req_t r,
                                  input gpio_bank_pkg::addr_t a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  function automatic gpio_bank_pkg::word_t rw_next(
      input gpio_bank_pkg::reg_req_t r,
      input gpio_bank_pkg::addr_t    a,
      input gpio_bank_pkg::word_t    cur);
    rw_next = wr_hit(r, a) ? r.wdata : cur;
  endfunction

  // ----------------------------------------------------------------
  // pin assignment registers
  // ----------------------------------------------------------------
  gpio_bank_pkg::word_t fsel_r;
  gpio_bank_pkg::word_t fsel_nxt;
  gpio_bank_pkg::word_t dir_r;
  gpio_bank_pkg::word_t dir_nxt;

  always_comb begin
    fsel_nxt = rw_next(req_i, `GB_OFF_FUNC_SEL, fsel_r);
    dir_nxt  = rw_next(req_i, `GB_OFF_DIR, dir_r);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fsel_r <= `GB_RST_FUNC_SEL;
      dir_r  <= `GB_RST_DIR;
    end else begin
      fsel_r <= fsel_nxt;
      dir_r  <= dir_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output drive option registers
  // ----------------------------------------------------------------
  gpio_bank_pkg::word_t float_r;
  gpio_bank_pkg::word_t float_nxt;
  gpio_bank_pkg::word_t drain_r;
  gpio_bank_pkg::word_t drain_nxt;

  always_comb begin
    float_nxt = rw_next(req_i, `GB_OFF_FLOAT, float_r);
    drain_nxt = rw_next(req_i, `GB_OFF_DRAIN, drain_r);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      float_r <= `GB_RST_FLOAT;
      drain_r <= `GB_RST_DRAIN;
    end else begin
      float_r <= float_nxt;
      drain_r <= drain_nxt;
    end
  end

  // ----------------------------------------------------------------
  // input pull registers
  // ----------------------------------------------------------------
  gpio_bank_pkg::word_t pu_r;
  gpio_bank_pkg::word_t pu_nxt;
  gpio_bank_pkg::word_t pd_r;
  gpio_bank_pkg::word_t pd_nxt;

  always_comb begin
    pu_nxt = rw_next(req_i, `GB_OFF_PULLUP, pu_r);
    pd_nxt = rw_next(req_i, `GB_OFF_PULLDOWN, pd_r);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pu_r <= `GB_RST_PULLUP;
      pd_r <= `GB_RST_PULLDOWN;
    end else begin
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt arming registers
  // ----------------------------------------------------------------
  gpio_bank_pkg::word_t allow_r;
  gpio_bank_pkg::word_t allow_nxt;
  gpio_bank_pkg::word_t rise_en_r;
  gpio_bank_pkg::word_t rise_en_nxt;
  gpio_bank_pkg::word_t fall_en_r;
  gpio_bank_pkg::word_t fall_en_nxt;

  always_comb begin
    allow_nxt   = rw_next(req_i, `GB_OFF_IRQ_ALLOW, allow_r);
    rise_en_nxt = rw_next(req_i, `GB_OFF_RISE_EN, rise_en_r);
    fall_en_nxt = rw_next(req_i, `GB_OFF_FALL_EN, fall_en_r);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      allow_r   <= `GB_RST_IRQ_ALLOW;
      rise_en_r <= `GB_RST_RISE_EN;
      fall_en_r <= `GB_RST_FALL_EN;
    end else begin
      allow_r   <= allow_nxt;
      rise_en_r <= rise_en_nxt;
      fall_en_r <= fall_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin roles
  // ----------------------------------------------------------------
  gpio_bank_pkg::word_t own_out;
  gpio_bank_pkg::word_t own_in;
  gpio_bank_pkg::word_t push_pull;
  gpio_bank_pkg::word_t open_drain;

  always_comb begin
    own_out    = fsel_r & dir_r;
    own_in     = fsel_r & ~dir_r;
    // float overrides both output kinds
    push_pull  = own_out & ~float_r & ~drain_r;
    open_drain = own_out & ~float_r & drain_r;
  end

  // ----------------------------------------------------------------
  // output write strobes
  // ----------------------------------------------------------------
  logic                 wr_set;
  logic                 wr_clr;
  logic                 wr_lvl;

  always_comb begin
    wr_set = wr_hit(req_i, `GB_OFF_SET);
    wr_clr = wr_hit(req_i, `GB_OFF_CLEAR);
    wr_lvl = wr_hit(req_i, `GB_OFF_LEVEL);
  end

  // ----------------------------------------------------------------
  // output level register
  // ----------------------------------------------------------------
  gpio_bank_pkg::word_t lvl_r;
  gpio_bank_pkg::word_t lvl_nxt;
  gpio_bank_pkg::word_t set_m;
  gpio_bank_pkg::word_t clr_m;
  gpio_bank_pkg::word_t st_m;

  always_comb begin
    set_m   = wr_set ? (req_i.wdata & own_out) : 16'h0000;
    clr_m   = wr_clr ? (req_i.wdata & own_out) : 16'h0000;
    // level write only reaches pins that are assigned outputs
    st_m    = wr_lvl ? own_out : 16'h0000;
    lvl_nxt = (lvl_r & ~st_m) | (req_i.wdata & st_m);
    lvl_nxt = (lvl_nxt | set_m) & ~clr_m;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lvl_r <= `GB_RST_LEVEL;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pad controls
  // ----------------------------------------------------------------
  gpio_bank_pkg::pad_ctrl_t pad_r;
  gpio_bank_pkg::pad_ctrl_t pad_nxt;
  gpio_bank_pkg::word_t     drv_out;

  always_comb begin
    // push-pull drives both levels, open drain only the low one
    drv_out            = push_pull |
                         (open_drain & ~lvl_r);
    pad_nxt.level      = lvl_r & own_out;
    // push-pull output pins are always driven, open-drain pins only while their level register is low, one cycle later through pad_r
    pad_nxt.drive_en   = drv_out;
    pad_nxt.pull_up    = (own_in & pu_r) |
                         (own_out & drain_r);
    pad_nxt.pull_down  = own_in & pd_r;
    pad_nxt.owned      = fsel_r;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pad_r <= '0;
    end else begin
      pad_r <= pad_nxt;
    end
  end

  assign pad_o = pad_r;

  // ----------------------------------------------------------------
  // input sampling and interrupts
  // ----------------------------------------------------------------
  logic [15:0] pin_sync;
  logic [15:0] rise_arm;
  logic [15:0] fall_arm;

  pin_sync u_pin_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_sync)
  );

  always_comb begin
    rise_arm = own_in & allow_r & rise_en_r;
    fall_arm = own_in & allow_r & fall_en_r;
  end

  edge_irq u_edge_irq (
    .mclk_i     (mclk_i),
    .reset_n_i  (reset_n_i),
    .level_i    (pin_sync),
    .rise_arm_i (rise_arm),
    .fall_arm_i (fall_arm),
    .ack_i      (irq_ack_i),
    .pending_o  (irq_pending_o),
    .irq_o      (irq_o)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  gpio_bank_pkg::reg_rsp_t rsp_r;
  gpio_bank_pkg::reg_rsp_t rsp_nxt;

  always_comb begin
    rsp_nxt.valid = req_i.rd;
    rsp_nxt.rdata = `GB_RD_ZERO;
    if (req_i.rd) begin
      unique case (req_i.addr)
        `GB_OFF_FUNC_SEL:  rsp_nxt.rdata = fsel_r;
        `GB_OFF_DIR:       rsp_nxt.rdata = dir_r;
        // write-only strobes read zero
        `GB_OFF_SET:       rsp_nxt.rdata = `GB_RD_ZERO;
        `GB_OFF_CLEAR:     rsp_nxt.rdata = `GB_RD_ZERO;
        `GB_OFF_LEVEL:     rsp_nxt.rdata = pin_sync & fsel_r;
        `GB_OFF_FLOAT:     rsp_nxt.rdata = float_r;
        `GB_OFF_DRAIN:     rsp_nxt.rdata = drain_r;
        `GB_OFF_PULLUP:    rsp_nxt.rdata = pu_r;
        `GB_OFF_PULLDOWN:  rsp_nxt.rdata = pd_r;
        `GB_OFF_IRQ_ALLOW: rsp_nxt.rdata = allow_r;
        `GB_OFF_RISE_EN:   rsp_nxt.rdata = rise_en_r;
        `GB_OFF_FALL_EN:   rsp_nxt.rdata = fall_en_r;
        // unmapped addresses read zero
        default:           rsp_nxt.rdata = `GB_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  assign rsp_o = rsp_r;

endmodule // gpio_bank_low_pins

/* File: core/pin_sync.sv */
module pin_sync (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // raw pin levels
  input  wire logic [15:0] async_i,
  // levels in the core clock domain
  output logic      [15:0] sync_o
);

  logic [15:0] meta_r;
  logic [15:0] meta_nxt;
  logic [15:0] sync_r;
  logic [15:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= 16'h0000;
      sync_r <= 16'h0000;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule // pin_sync

/* File: pkg/gpio_bank_pkg.sv */
`include "gpio_bank_regs.svh"

package gpio_bank_pkg;

  typedef logic [`GB_DATA_W-1:0] word_t;
  typedef logic [`GB_ADDR_W-1:0] addr_t;

  // register access request, one cycle per access
  typedef struct packed {
    logic  wr;
    logic  rd;
    addr_t addr;
    word_t wdata;
  } reg_req_t;

  // read answer
  typedef struct packed {
    logic  valid;
    word_t rdata;
  } reg_rsp_t;

  // pad controls for the sixteen pins
  typedef struct packed {
    word_t level;
    word_t drive_en;
    word_t pull_up;
    word_t pull_down;
    word_t owned;
  } pad_ctrl_t;

endpackage

/* File: pkg/gpio_bank_regs.svh */
`ifndef GPIO_BANK_REGS_SVH
`define GPIO_BANK_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define GB_ADDR_W          10
`define GB_DATA_W          16
`define GB_OFF_FUNC_SEL    10'h3c0
`define GB_OFF_DIR         10'h3c1
`define GB_OFF_SET         10'h3c2
`define GB_OFF_CLEAR       10'h3c3
`define GB_OFF_LEVEL       10'h3c4
`define GB_OFF_FLOAT       10'h3c5
`define GB_OFF_DRAIN       10'h3c6
`define GB_OFF_PULLUP      10'h3c7
`define GB_OFF_PULLDOWN    10'h3c8
`define GB_OFF_IRQ_ALLOW   10'h3c9
`define GB_OFF_RISE_EN     10'h3ca
`define GB_OFF_FALL_EN     10'h3cb

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GB_RST_FUNC_SEL    16'h0000
`define GB_RST_DIR         16'h0000
`define GB_RST_LEVEL       16'h0000
`define GB_RST_FLOAT       16'h0000
`define GB_RST_DRAIN       16'h0000
`define GB_RST_PULLUP      16'hffff
`define GB_RST_PULLDOWN    16'h0000
`define GB_RST_IRQ_ALLOW   16'h0000
`define GB_RST_RISE_EN     16'hffff
`define GB_RST_FALL_EN     16'hffff
`define GB_RD_ZERO         16'h0000

`endif

/* File: verif/gpio_bank_low_pins_props.sv */
module gpio_bank_low_pins_props (
  // clock and reset
  input wire logic                     mclk_i,
  input wire logic                     reset_n_i,
  // watched ports
  input wire gpio_bank_pkg::reg_req_t  req_i,
  input wire gpio_bank_pkg::reg_rsp_t  rsp_o,
  input wire logic [15:0]              pin_in_i,
  input wire gpio_bank_pkg::pad_ctrl_t pad_o,
  input wire logic [15:0]              irq_ack_i,
  input wire logic [15:0]              irq_pending_o,
  input wire logic                     irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] held_r;
  always_ff @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i) held_r <= 16'h0000;
    else held_r <= irq_pending_o & ~irq_ack_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  chk_read_answer: assert property (req_i.rd |=> rsp_o.valid)
    else $error("read got no answer");
  chk_no_spurious: assert property (!req_i.rd |=> !rsp_o.valid)
    else $error("answer without read");
  chk_rsp_idle: assert property (!rsp_o.valid |-> rsp_o.rdata == 16'h0000)
    else $error("read data not zero when idle");
  chk_irq_or: assert property (irq_o == (|irq_pending_o))
    else $error("irq not the or of pending");
  chk_unowned_quiet: assert property (((pad_o.level | pad_o.pull_up | pad_o.pull_down)
    & ~pad_o.owned) == 16'h0000) else $error("unowned pin controlled");
  chk_drive_owned: assert property ((pad_o.drive_en & ~pad_o.owned) == 16'h0000)
    else $error("unowned pin driven");
  chk_read_masked: assert property (rsp_o.valid && $past(req_i.addr) == 10'h3c4
    |-> (rsp_o.rdata & ~pad_o.owned) == 16'h0000) else $error("unowned pin read");
  chk_pend_sticky: assert property ((irq_pending_o & held_r) == held_r)
    else $error("pending lost without ack");
  chk_irq_inputs: assert property ((irq_pending_o & ~$past(irq_pending_o)
    & (~pad_o.owned | pad_o.drive_en)) == 16'h0000) else $error("event on non input");
  cover property (irq_o);
  cover property (req_i.rd ##1 rsp_o.valid);
  cover property (pad_o.drive_en != 16'h0000);
endmodule // gpio_bank_low_pins_props

bind gpio_bank_low_pins gpio_bank_low_pins_props u_props (.mclk_i(mclk_i),
  .reset_n_i(reset_n_i), .req_i(req_i), .rsp_o(rsp_o), .pin_in_i(pin_in_i), .pad_o(pad_o),
  .irq_ack_i(irq_ack_i), .irq_pending_o(irq_pending_o), .irq_o(irq_o));

/* File: verif/pin_peripheral.sv */
module pin_peripheral (
  // clock
  input  wire logic                     mclk_i,
  // pad controls and far-side drive
  input  wire gpio_bank_pkg::pad_ctrl_t pad_i,
  input  wire logic [15:0]              ext_en_i,
  input  wire logic [15:0]              ext_val_i,
  // resolved pin levels
  output logic      [15:0]              pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] noise_r = 16'h5555;
  // undriven, unpulled pins wander
  always_ff @(posedge mclk_i) noise_r <= ~noise_r;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pad_i.drive_en[i]) pin_o[i] = pad_i.level[i];
      else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
      else if (pad_i.pull_up[i]) pin_o[i] = 1'b1;
      else if (pad_i.pull_down[i]) pin_o[i] = 1'b0;
      else pin_o[i] = noise_r[i];
    end
  end
endmodule // pin_peripheral

/* File: verif/tb_gpio_bank_low_pins.sv */
module tb_gpio_bank_low_pins;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [9:0] a; logic [15:0] d;} row_t;
  logic                     mclk_i = 1'b0;
  logic                     reset_n_i = 1'b0;
  gpio_bank_pkg::reg_req_t  req_i = '0;
  gpio_bank_pkg::reg_rsp_t  rsp_o;
  gpio_bank_pkg::pad_ctrl_t pad_o;
  logic [15:0]              pin_w;
  logic [15:0]              pend;
  logic                     irq;
  logic [15:0]              ack = 16'h0000;
  logic [15:0]              ext_en = 16'h0000;
  logic [15:0]              ext_val = 16'h0000;
  int                       errors = 0;
  int                       checked = 0;
  row_t rows [13] = '{'{10'h3c0, 16'h0000}, '{10'h3c1, 16'h0000}, '{10'h3c2, 16'h0000},
    '{10'h3c3, 16'h0000}, '{10'h3c4, 16'h0000}, '{10'h3c5, 16'h0000}, '{10'h3c6, 16'h0000},
    '{10'h3c7, 16'hffff}, '{10'h3c8, 16'h0000}, '{10'h3c9, 16'h0000}, '{10'h3ca, 16'hffff},
    '{10'h3cb, 16'hffff}, '{10'h3cc, 16'h0000}};
  gpio_bank_low_pins dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req_i),
    .rsp_o(rsp_o), .pin_in_i(pin_w), .pad_o(pad_o), .irq_ack_i(ack),
    .irq_pending_o(pend), .irq_o(irq));
  pin_peripheral peer (.mclk_i(mclk_i), .pad_i(pad_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_o(pin_w));
  always #50 mclk_i = ~mclk_i;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #10;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    req_i = '0;
    cyc(1);
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    cyc(1);
    req_i = '0;
    chk(rsp_o.rdata, e);
    cyc(1);
  endtask
  task automatic ack_pins(input logic [15:0] m);
    ack = m;
    cyc(1);
    ack = 16'h0000;
    cyc(1);
    chk(pend, 16'h0000);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    test_done;
  end
  initial begin
    cyc(10);
    reset_n_i = 1'b1;
    cyc(1);
    foreach (rows[i]) rd(rows[i].a, rows[i].d);
    chk(pend, 16'h0000);
    note("reset");
    ext_en = 16'h00f0;
    ext_val = 16'h0050;
    wr(10'h3c0, 16'h00ff);
    wr(10'h3c1, 16'h000f);
    wr(10'h3c2, 16'hffff);
    cyc(3);
    chk(pad_o.level, 16'h000f);
    chk(pad_o.drive_en, 16'h000f);
    chk(pad_o.pull_up, 16'h00f0);
    chk(pad_o.owned, 16'h00ff);
    rd(10'h3c4, 16'h005f);
    rd(10'h3c2, 16'h0000);
    wr(10'h3c3, 16'h0005);
    cyc(3);
    chk(pad_o.level, 16'h000a);
    wr(10'h3c4, 16'h00f5);
    cyc(3);
    chk(pad_o.level, 16'h0005);
    chk(pad_o.drive_en, 16'h000f);
    note("outputs");
    wr(10'h3c5, 16'h0001);
    cyc(3);
    chk(pad_o.drive_en, 16'h000e);
    wr(10'h3c5, 16'h0000);
    wr(10'h3c6, 16'h0003);
    cyc(3);
    chk(pad_o.drive_en, 16'h000e);
    chk(pad_o.pull_up, 16'h00f3);
    rd(10'h3c4, 16'h0055);
    wr(10'h3c6, 16'h0000);
    note("pad modes");
    wr(10'h3c7, 16'h0000);
    wr(10'h3c8, 16'h00f0);
    cyc(3);
    chk(pad_o.pull_up, 16'h0000);
    chk(pad_o.pull_down, 16'h00f0);
    rd(10'h3c8, 16'h00f0);
    wr(10'h3cc, 16'hffff);
    rd(10'h3cc, 16'h0000);
    note("pulls");
    wr(10'h3c9, 16'h0031);
    wr(10'h3cb, 16'h0010);
    ext_val = 16'h0030;
    cyc(6);
    chk(pend, 16'h0020);
    chk({15'h0000, irq}, 16'h0001);
    ack_pins(16'h0020);
    ext_val = 16'h0010;
    cyc(6);
    chk(pend, 16'h0000);
    ext_val = 16'h0000;
    cyc(6);
    chk(pend, 16'h0010);
    ack_pins(16'h0010);
    ext_val = 16'h0010;
    cyc(6);
    chk(pend, 16'h0010);
    ack_pins(16'h0010);
    wr(10'h3c3, 16'h0001);
    cyc(6);
    chk(pend, 16'h0000);
    wr(10'h3ca, 16'h0000);
    rd(10'h3ca, 16'h0000);
    ext_val = 16'h0030;
    cyc(6);
    chk(pend, 16'h0000);
    note("interrupts");
    test_done;
  end
endmodule // tb_gpio_bank_low_pins
